// *** logic/pwcap_top.sv ***
// pulse width capture channel with register port and interrupt
//
// Overview of operation
// - count from start edge of capture input until its opposite edge
// - start edge rising or falling, rising by default; stop on opposite
// - one-shot mode disables captures after one measurement until re-enabled
// - periodic mode, the default, measures back to back
// - auto start, default true, enables at configuration; else wait enable
// - capture input is pin a or pin b, pin a by default
// - capture filter samples at clock /1,/4,/16,/64 or bypass, default
// - filter output changes only after three equal consecutive samples
// - counter advances at clock /1,/4,/16,/64,/256,/1024, default /1
// - two pins per channel; the other pin may gate captures
// - enable level none, the default, captures always enabled
// - low or high level: start a capture only while enable pin at that level
// - enable input has its own filter, same taps, default none
// - completion reports captured count with overflows of the measurement
`timescale 1ns/1ps
`include "pwcap_cfg.svh"
module pwcap_top #(
	parameter int CNT_W = 32,
	parameter int OVF_W = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic channel_pin_a,
	input wire logic channel_pin_b,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic irq,
	output logic running
);
	// the register port is one word wide, so neither count may exceed it
	if (CNT_W < 2 || CNT_W > 32) begin
		$error("pwcap_top: CNT_W out of range");
	end
	if (OVF_W < 1 || OVF_W > 32) begin
		$error("pwcap_top: OVF_W out of range");
	end

	typedef struct packed {
		logic [1:0] sa;
		logic [1:0] sb;
		logic [31:0] ctrl;
		logic [1:0] mask;
		logic [1:0] stat;
		logic enabled;
		pwcap_pkg::pwcap_state_t st;
		logic [9:0] div;
		logic [`PWCAP_FLT_SAMPLES-1:0] shs;
		logic [`PWCAP_FLT_SAMPLES-1:0] she;
		logic fs;
		logic fe;
		logic prev_s;
		logic [CNT_W-1:0] cnt;
		logic [OVF_W-1:0] ovf;
		logic [CNT_W-1:0] cap_cnt;
		logic [OVF_W-1:0] cap_ovf;
		logic [31:0] rdata;
	} pwcap_regs_t;

	pwcap_regs_t q_r;
	pwcap_regs_t q_nxt;

	// true when the free divider reaches the end of a tap period
	function automatic logic tap(input logic [9:0] d, input logic [2:0] sel);
		logic t;
		t = 1'b0;
		case (sel)
			3'd0: t = 1'b1;
			3'd1: t = (d[1:0] == 2'h3);
			3'd2: t = (d[3:0] == 4'hf);
			3'd3: t = (d[5:0] == 6'h3f);
			3'd4: t = (d[7:0] == 8'hff);
			3'd5: t = (d == 10'h3ff);
			default: t = 1'b0;
		endcase
		return t;
	endfunction

	// filter sample tick; none never ticks and the sample is bypassed
	function automatic logic ftick(input logic [9:0] d,
			input pwcap_pkg::pwcap_flt_t f);
		logic t;
		t = 1'b0;
		case (f)
			pwcap_pkg::PWCAP_FLT_D1: t = tap(d, 3'd0);
			pwcap_pkg::PWCAP_FLT_D4: t = tap(d, 3'd1);
			pwcap_pkg::PWCAP_FLT_D16: t = tap(d, 3'd2);
			pwcap_pkg::PWCAP_FLT_D64: t = tap(d, 3'd3);
			default: t = 1'b0;
		endcase
		return t;
	endfunction

	// a level passes only after a full run of equal samples
	function automatic logic vote(
			input logic [`PWCAP_FLT_SAMPLES-1:0] h,
			input logic held);
		logic v;
		v = held;
		if (&h)
			v = 1'b1;
		else if (~|h)
			v = 1'b0;
		return v;
	endfunction

	always_comb begin
		logic raw_s;
		logic raw_e;
		logic sig;
		logic en_in;
		logic gate;
		logic rise;
		logic fall;
		logic start_e;
		logic stop_e;
		logic cnt_tick;
		logic wrap;
		logic done_ev;
		logic ovf_ev;
		logic en_cmd;
		logic dis_cmd;
		pwcap_pkg::pwcap_flt_t sflt;
		pwcap_pkg::pwcap_flt_t eflt;
		pwcap_pkg::pwcap_enlvl_t enlvl;
		raw_s = 1'b0;
		raw_e = 1'b0;
		sig = 1'b0;
		en_in = 1'b0;
		gate = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		start_e = 1'b0;
		stop_e = 1'b0;
		cnt_tick = 1'b0;
		wrap = 1'b0;
		done_ev = 1'b0;
		ovf_ev = 1'b0;
		en_cmd = 1'b0;
		dis_cmd = 1'b0;
		sflt = pwcap_pkg::PWCAP_FLT_NONE;
		eflt = pwcap_pkg::PWCAP_FLT_NONE;
		enlvl = pwcap_pkg::PWCAP_EN_NONE;
		q_nxt = q_r;
		sflt = pwcap_pkg::pwcap_flt_t'(q_r.ctrl[`PWCAP_CTRL_SFLT +: 3]);
		eflt = pwcap_pkg::pwcap_flt_t'(q_r.ctrl[`PWCAP_CTRL_EFLT +: 3]);
		enlvl = pwcap_pkg::pwcap_enlvl_t'(q_r.ctrl[`PWCAP_CTRL_ENLVL +: 2]);
		en_cmd = wr && addr == `PWCAP_ADDR_CMD && wdata[`PWCAP_CMD_ENABLE];
		dis_cmd = wr && addr == `PWCAP_ADDR_CMD && wdata[`PWCAP_CMD_DISABLE];

		// pins pass two flops; only the second stage is read below
		q_nxt.sa = {q_r.sa[0], channel_pin_a};
		q_nxt.sb = {q_r.sb[0], channel_pin_b};
		q_nxt.div = q_r.div + 10'h001;

		// pick capture pin, the other one is the enable pin
		raw_s = q_r.ctrl[`PWCAP_CTRL_PINB] ? q_r.sb[1] : q_r.sa[1];
		raw_e = q_r.ctrl[`PWCAP_CTRL_PINB] ? q_r.sa[1] : q_r.sb[1];

		// three-sample filters on both inputs
		if (ftick(q_r.div, sflt)) begin
			q_nxt.shs = {q_r.shs[`PWCAP_FLT_SAMPLES-2:0], raw_s};
			q_nxt.fs = vote(q_nxt.shs, q_r.fs);
		end
		if (ftick(q_r.div, eflt)) begin
			q_nxt.she = {q_r.she[`PWCAP_FLT_SAMPLES-2:0], raw_e};
			q_nxt.fe = vote(q_nxt.she, q_r.fe);
		end
		sig = (sflt == pwcap_pkg::PWCAP_FLT_NONE) ? raw_s : q_r.fs;
		en_in = (eflt == pwcap_pkg::PWCAP_FLT_NONE) ? raw_e : q_r.fe;
		q_nxt.prev_s = sig;

		case (enlvl)
			pwcap_pkg::PWCAP_EN_LOW: gate = ~en_in;
			pwcap_pkg::PWCAP_EN_HIGH: gate = en_in;
			default: gate = 1'b1;
		endcase

		rise = sig && !q_r.prev_s;
		fall = !sig && q_r.prev_s;
		start_e = q_r.ctrl[`PWCAP_CTRL_EDGE] ? fall : rise;
		stop_e = q_r.ctrl[`PWCAP_CTRL_EDGE] ? rise : fall;
		cnt_tick = tap(q_r.div, q_r.ctrl[`PWCAP_CTRL_DIV +: 3]);

		if (en_cmd)
			q_nxt.enabled = 1'b1;
		if (dis_cmd)
			q_nxt.enabled = 1'b0;

		case (q_r.st)
			pwcap_pkg::PWCAP_IDLE: begin
				if (q_r.enabled)
					q_nxt.st = pwcap_pkg::PWCAP_ARMED;
			end
			pwcap_pkg::PWCAP_ARMED: begin
				if (!q_r.enabled) begin
					q_nxt.st = pwcap_pkg::PWCAP_IDLE;
				end else if (start_e && gate) begin
					q_nxt.cnt = '0;
					q_nxt.ovf = '0;
					q_nxt.st = pwcap_pkg::PWCAP_COUNT;
				end
			end
			pwcap_pkg::PWCAP_COUNT: begin
				if (!q_r.enabled) begin
					q_nxt.st = pwcap_pkg::PWCAP_IDLE;
				end else if (stop_e) begin
					q_nxt.cap_cnt = q_r.cnt;
					q_nxt.cap_ovf = q_r.ovf;
					done_ev = 1'b1;
					if (q_r.ctrl[`PWCAP_CTRL_ONESHOT]) begin
						q_nxt.enabled = en_cmd && !dis_cmd;
						q_nxt.st = pwcap_pkg::PWCAP_IDLE;
					end else begin
						q_nxt.st = pwcap_pkg::PWCAP_ARMED;
					end
				end else if (cnt_tick) begin
					q_nxt.cnt = q_r.cnt + 1'b1;
					wrap = &q_r.cnt;
					if (wrap) begin
						q_nxt.ovf = q_r.ovf + 1'b1;
						ovf_ev = 1'b1;
					end
				end
			end
			default: q_nxt.st = pwcap_pkg::PWCAP_IDLE;
		endcase

		// register writes; a new configuration restarts in line with auto start
		if (wr && addr == `PWCAP_ADDR_CTRL) begin
			q_nxt.ctrl = wdata;
			q_nxt.enabled = wdata[`PWCAP_CTRL_AUTO];
			q_nxt.st = pwcap_pkg::PWCAP_IDLE;
			// preload filters and edge history from the newly chosen pins,
			// else a stale level would look like an edge after the change
			q_nxt.fs = wdata[`PWCAP_CTRL_PINB] ? q_r.sb[1] : q_r.sa[1];
			q_nxt.fe = wdata[`PWCAP_CTRL_PINB] ? q_r.sa[1] : q_r.sb[1];
			q_nxt.shs = {`PWCAP_FLT_SAMPLES{q_nxt.fs}};
			q_nxt.she = {`PWCAP_FLT_SAMPLES{q_nxt.fe}};
			q_nxt.prev_s = q_nxt.fs;
		end
		if (wr && addr == `PWCAP_ADDR_MASK)
			q_nxt.mask = wdata[1:0];

		// read of status clears it, but a same-cycle event still lands
		if (rd && addr == `PWCAP_ADDR_STAT)
			q_nxt.stat = 2'b00;
		if (done_ev)
			q_nxt.stat[`PWCAP_ST_DONE] = 1'b1;
		if (ovf_ev)
			q_nxt.stat[`PWCAP_ST_OVF] = 1'b1;

		q_nxt.rdata = 32'h0000_0000;
		if (rd) begin
			case (addr)
				`PWCAP_ADDR_CTRL: q_nxt.rdata = q_r.ctrl;
				`PWCAP_ADDR_STAT: q_nxt.rdata = {30'h0, q_r.stat};
				`PWCAP_ADDR_MASK: q_nxt.rdata = {30'h0, q_r.mask};
				`PWCAP_ADDR_COUNT: q_nxt.rdata = 32'(q_r.cap_cnt);
				`PWCAP_ADDR_OVF: q_nxt.rdata = 32'(q_r.cap_ovf);
				`PWCAP_ADDR_RUN:
					q_nxt.rdata = {30'h0,
						q_r.st == pwcap_pkg::PWCAP_COUNT, q_r.enabled};
				default: q_nxt.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q_r.sa <= 2'b00;
			q_r.sb <= 2'b00;
			q_r.ctrl <= `PWCAP_CTRL_RESET;
			q_r.mask <= 2'b00;
			q_r.stat <= 2'b00;
			q_r.enabled <= 1'b1;
			q_r.st <= pwcap_pkg::PWCAP_IDLE;
			q_r.div <= 10'h000;
			q_r.shs <= '0;
			q_r.she <= '0;
			q_r.fs <= 1'b0;
			q_r.fe <= 1'b0;
			q_r.prev_s <= 1'b0;
			q_r.cnt <= '0;
			q_r.ovf <= '0;
			q_r.cap_cnt <= '0;
			q_r.cap_ovf <= '0;
			q_r.rdata <= 32'h0000_0000;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign rdata = q_r.rdata;
	assign irq = |(q_r.stat & q_r.mask);
	assign running = (q_r.st == pwcap_pkg::PWCAP_COUNT);
endmodule

// *** logic/pwcap_cfg.svh ***
// constants for the pulse width capture block
`ifndef PWCAP_CFG_SVH
`define PWCAP_CFG_SVH
`define PWCAP_ADDR_CTRL 4'h0
`define PWCAP_ADDR_CMD 4'h1
`define PWCAP_ADDR_STAT 4'h2
`define PWCAP_ADDR_MASK 4'h3
`define PWCAP_ADDR_COUNT 4'h4
`define PWCAP_ADDR_OVF 4'h5
`define PWCAP_ADDR_RUN 4'h6
// control field positions
`define PWCAP_CTRL_EDGE 0
`define PWCAP_CTRL_ONESHOT 1
`define PWCAP_CTRL_AUTO 2
`define PWCAP_CTRL_PINB 3
`define PWCAP_CTRL_SFLT 4
`define PWCAP_CTRL_DIV 8
`define PWCAP_CTRL_ENLVL 12
`define PWCAP_CTRL_EFLT 16
// rising, periodic, auto start, pin a, no filters, divide by one
`define PWCAP_CTRL_RESET 32'h0000_0004
// command bits
`define PWCAP_CMD_ENABLE 0
`define PWCAP_CMD_DISABLE 1
// status bits
`define PWCAP_ST_DONE 0
`define PWCAP_ST_OVF 1
`define PWCAP_FLT_SAMPLES 3
`endif

// *** logic/pwcap_pkg.sv ***
// types of the pulse width capture block
package pwcap_pkg;
	typedef enum logic [1:0] {
		PWCAP_IDLE,
		PWCAP_ARMED,
		PWCAP_COUNT
	} pwcap_state_t;
	typedef enum logic [2:0] {
		PWCAP_FLT_NONE,
		PWCAP_FLT_D1,
		PWCAP_FLT_D4,
		PWCAP_FLT_D16,
		PWCAP_FLT_D64
	} pwcap_flt_t;
	typedef enum logic [1:0] {
		PWCAP_EN_NONE,
		PWCAP_EN_LOW,
		PWCAP_EN_HIGH
	} pwcap_enlvl_t;
endpackage

// *** verif/pwcap_src.sv ***
// pulse source and gate level driver facing the capture pins
`timescale 1ns/1ps
module pwcap_src (
	input wire logic clk,
	output logic pin_a,
	output logic pin_b
);
	initial begin
		pin_a = 1'b0;
		pin_b = 1'b0;
	end
	// gate level goes out well before the start edge and is held to the end
	task automatic pulse(input int w, input logic pol, input logic gate);
		@(posedge clk);
		pin_a <= ~pol;
		pin_b <= gate;
		repeat (8) @(posedge clk);
		pin_a <= pol;
		repeat (w) @(posedge clk);
		pin_a <= ~pol;
		repeat (8) @(posedge clk);
	endtask
endmodule

// *** verif/pwcap_monitor.sv ***
// port checker for the pulse width capture block
`timescale 1ns/1ps
module pwcap_monitor (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic irq,
	input wire logic running
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	rdata_idle_a:
		assert property (!$past(rd) |-> rdata == '0)
		else $error("stray rdata");
	unmapped_rd_a:
		assert property (rd && addr > 4'h6 |=> rdata == '0)
		else $error("unmapped data");
	mask_width_a:
		assert property (rd && addr == 4'h3 |=> rdata[31:2] == '0)
		else $error("mask width");
	stat_bits_a:
		assert property (rd && addr == 4'h2 |=> rdata[31:2] == '0)
		else $error("status width");
	mask_off_a:
		assert property (wr && addr == 4'h3 && wdata[1:0] == 2'b00 |-> ##2 !irq)
		else $error("masked irq");
	stat_clear_a:
		assert property (rd && addr == 4'h2 && !running |-> ##2 !irq)
		else $error("status kept");
	// a sticky event may only go away through a read or a register write
	irq_sticky_a:
		assert property ($fell(irq) |-> $past(rd) || $past(rd, 2) ||
			$past(wr) || $past(wr, 2))
		else $error("irq dropped");
	ctrl_idle_a:
		assert property (wr && addr == 4'h0 |-> ##2 !running)
		else $error("ctrl not idle");
	run_c: cover property ($rose(running));
	irq_c: cover property ($rose(irq));
	count_c: cover property (rd && addr == 4'h4);
endmodule
bind pwcap_top pwcap_monitor mon (.clk(clk), .resetn(resetn), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
	.running(running));

// *** verif/tb_pulse_width_capture.sv ***
// self-checking bench for the pulse width capture block
`timescale 1ns/1ps
module tb_pulse_width_capture;
	logic clk, resetn, wr, rd, irq, running, pa, pb;
	logic [3:0] addr;
	logic [31:0] wdata, rdata;
	int n_mismatch = 0;
	int total_checks = 0;
	pwcap_top dut (.clk(clk), .resetn(resetn), .channel_pin_a(pa),
		.channel_pin_b(pb), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .irq(irq), .running(running));
	pwcap_src src (.clk(clk), .pin_a(pa), .pin_b(pb));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [3:0] a, input int lo, input int hi);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		total_checks++;
		if ((^rdata) === 1'bx || rdata < lo || rdata > hi) begin
			n_mismatch++;
			$display("BAD %0t reg %0h got %0h", $time, a, rdata);
		end
	endtask
	task automatic meas(input int w, input logic pol, input logic g,
		input int lo, input int hi);
		src.pulse(w, pol, g);
		#1;
		for (int i = 0; i < 700 && irq !== 1'b1; i++)
			#8;
		if (irq !== 1'b1) begin
			n_mismatch++;
			$display("BAD %0t no completion", $time);
			tally_and_finish;
		end
		rd_chk(4'h4, lo, hi);
		rd_chk(4'h2, 1, 1);
	endtask
	task automatic none_seen(input int w, input logic pol, input logic g);
		src.pulse(w, pol, g);
		rd_chk(4'h2, 0, 0);
	endtask
	task automatic t_default;
		wr_reg(4'h3, 32'h0000_0003);
		rd_chk(4'h0, 4, 4);
		rd_chk(4'hf, 0, 0);
		meas(20, 1'b1, 1'b0, 19, 21);
		rd_chk(4'h5, 0, 0);
		meas(30, 1'b1, 1'b0, 29, 31);
	endtask
	task automatic t_oneshot;
		wr_reg(4'h0, 32'h0000_0107);
		meas(40, 1'b0, 1'b0, 9, 11);
		rd_chk(4'h6, 0, 0);
		none_seen(40, 1'b0, 1'b0);
		wr_reg(4'h1, 32'h0000_0001);
		rd_chk(4'h6, 1, 1);
		meas(40, 1'b0, 1'b0, 9, 11);
	endtask
	task automatic t_auto;
		wr_reg(4'h0, 32'h0000_0000);
		none_seen(20, 1'b1, 1'b0);
		wr_reg(4'h1, 32'h0000_0001);
		meas(20, 1'b1, 1'b0, 19, 21);
		wr_reg(4'h1, 32'h0000_0002);
		none_seen(20, 1'b1, 1'b0);
	endtask
	task automatic t_gate;
		wr_reg(4'h0, 32'h0000_2004);
		none_seen(20, 1'b1, 1'b0);
		meas(20, 1'b1, 1'b1, 19, 21);
		wr_reg(4'h0, 32'h0000_1004);
		meas(20, 1'b1, 1'b0, 19, 21);
		none_seen(20, 1'b1, 1'b1);
		wr_reg(4'h0, 32'h0000_000c);
		none_seen(20, 1'b1, 1'b0);
	endtask
	// slowest tap: width is quantised to the sample interval
	task automatic t_filter;
		wr_reg(4'h0, 32'h0000_0044);
		none_seen(2, 1'b1, 1'b0);
		meas(400, 1'b1, 1'b0, 330, 470);
	endtask
	initial begin
		resetn = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 32'h0000_0000;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		t_default;
		t_oneshot;
		t_auto;
		t_gate;
		t_filter;
		wr_reg(4'h3, 32'h0000_0000);
		tally_and_finish;
	end
endmodule
